// [rtl/ssr_defs.vh]
`ifndef SSR_DEFS_VH
`define SSR_DEFS_VH

// Register byte offsets
`define SSR_OFF_CTRL_ONE  8'h00
`define SSR_OFF_CTRL_TWO  8'h04
`define SSR_OFF_STATUS    8'h08
`define SSR_OFF_BUF_BASE  8'h20
`define SSR_BUF_MASK      8'hE0

// Field positions of serial_control_one
`define SSR_START_POS     0
`define SSR_ABORT_POS     1
`define SSR_MODE_LO       2
`define SSR_MODE_HI       3
`define SSR_EXT_POS       4

// Field positions of serial_status_reg
`define SSR_ACTIVE_POS    0
`define SSR_SHIFT_POS     1
`define SSR_WAIT_POS      2

// Transfer modes
`define SSR_MODE_RX8      2'h0
`define SSR_MODE_RX4      2'h1
`define SSR_MODE_TXRX8    2'h2

// Reset values
`define SSR_MODE_RST      2'h0
`define SSR_COUNT_RST     3'h0
`define SSR_BUF_RST       8'h00

// AXI responses
`define SSR_RESP_OKAY     2'h0
`define SSR_RESP_SLVERR   2'h2

// Internal serial clock: 500 ns half period in 25 ns system cycles
`define SSR_SCK_HALF_CYC  8'h14

// Bits per word, counted from zero
`define SSR_LAST_BIT8     3'h7
`define SSR_LAST_BIT4     3'h3

`endif

// [rtl/ssr_sync.v]
module ssr_sync (
	// Clock and reset
	input  wire       clk_i,
	input  wire       nrst_i,
	// Asynchronous levels in, synchronised levels out
	input  wire [1:0] d_i,
	output reg  [1:0] q_o
);

	reg [1:0] meta;

	always @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			meta <= 2'h3;
			q_o  <= 2'h3;
		end
		else
		begin
			meta <= d_i;
			q_o  <= meta;
		end
	end

endmodule

// [rtl/ssr_core.v]
`include "ssr_defs.vh"

module ssr_core (
	// Clock and reset
	input  wire        clk_i,
	input  wire        nrst_i,
	// AXI4-Lite write address
	input  wire [7:0]  s_axi_awaddr_i,
	input  wire        s_axi_awvalid_i,
	output reg         s_axi_awready_o,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	input  wire        s_axi_wvalid_i,
	output reg         s_axi_wready_o,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp_o,
	output reg         s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	// AXI4-Lite read address
	input  wire [7:0]  s_axi_araddr_i,
	input  wire        s_axi_arvalid_i,
	output reg         s_axi_arready_o,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata_o,
	output reg  [1:0]  s_axi_rresp_o,
	output reg         s_axi_rvalid_o,
	input  wire        s_axi_rready_i,
	// Serial pins
	input  wire        sck_i,
	output reg         sck_o,
	output reg         sck_oe_n_o,
	input  wire        si_i,
	output reg         so_o,
	// Event
	output reg         serial_done_irq_o
);

	localparam [3:0] ST_IDLE  = 4'h1;
	localparam [3:0] ST_READY = 4'h2;
	localparam [3:0] ST_LOW   = 4'h4;
	localparam [3:0] ST_HIGH  = 4'h8;
	localparam [7:0] HALF_LAST = `SSR_SCK_HALF_CYC - 8'h01;

	reg  [3:0]  state;
	reg  [7:0]  data_buffer_entries [0:7];
	reg  [7:0]  shreg;
	reg  [2:0]  bit_cnt;
	reg  [2:0]  word_idx;
	reg  [2:0]  word_count;
	reg  [1:0]  transfer_mode_field;
	reg         transfer_start_bit;
	reg         ext_clk;
	reg         transfer_active_flag;
	reg         unread;
	reg  [7:0]  div_cnt;
	reg         tick;
	reg         sck_d;
	reg  [7:0]  aw_addr;
	reg  [31:0] w_data;
	reg         w_lane0;
	reg  [31:0] rd_val;
	wire [1:0]  sync_q;
	integer     i;

	// Clock and data pins cross into the system clock domain
	ssr_sync u_sync (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.d_i    ({sck_i, si_i}),
		.q_o    (sync_q)
	);

	function is_buf;
		input [7:0] a;
		begin
			is_buf = ((a & `SSR_BUF_MASK) == `SSR_OFF_BUF_BASE) && (a[1:0] == 2'h0);
		end
	endfunction

	function addr_ok;
		input [7:0] a;
		begin
			addr_ok = is_buf(a) || (a == `SSR_OFF_CTRL_ONE) || (a == `SSR_OFF_CTRL_TWO) ||
				(a == `SSR_OFF_STATUS);
		end
	endfunction

	wire       sck_s     = sync_q[1];
	wire       si_s      = sync_q[0];
	wire       sck_fall  = sck_d & ~sck_s;
	wire       sck_rise  = ~sck_d & sck_s;
	wire       fall_ev   = ext_clk ? sck_fall : tick;
	wire       rise_ev   = ext_clk ? sck_rise : tick;
	wire       txrx      = (transfer_mode_field == `SSR_MODE_TXRX8);
	wire       four_bit  = (transfer_mode_field == `SSR_MODE_RX4);
	wire [2:0] last_bit  = four_bit ? `SSR_LAST_BIT4 : `SSR_LAST_BIT8;
	wire [7:0] next_sh   = {si_s, shreg[7:1]};
	wire [7:0] rx_word   = four_bit ? {4'h0, next_sh[7:4]} : next_sh;
	wire       wr_fire   = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
	wire       rd_fire   = s_axi_arvalid_i && s_axi_arready_o;
	wire       wr_ctl1   = wr_fire && w_lane0 && (aw_addr == `SSR_OFF_CTRL_ONE);
	wire       abort_wr  = wr_ctl1 && w_data[`SSR_ABORT_POS];
	wire       shifting  = (state == ST_LOW) || (state == ST_HIGH);
	wire       waiting   = (state == ST_READY) && !ext_clk && unread && transfer_start_bit;

	always @*
	begin
		rd_val = 32'h0000_0000;
		if (s_axi_araddr_i == `SSR_OFF_CTRL_ONE)
			rd_val = {27'h0, ext_clk, transfer_mode_field, 1'b0, transfer_start_bit};
		else if (s_axi_araddr_i == `SSR_OFF_CTRL_TWO)
			rd_val = {29'h0, word_count};
		else if (s_axi_araddr_i == `SSR_OFF_STATUS)
			rd_val = {29'h0, waiting, shifting, transfer_active_flag};
		else if (is_buf(s_axi_araddr_i))
			rd_val = {24'h0, data_buffer_entries[s_axi_araddr_i[4:2]]};
	end

	// Internal serial clock half-period divider
	always @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			div_cnt <= 8'h00;
			tick    <= 1'b0;
			sck_d   <= 1'b1;
		end
		else
		begin
			sck_d <= sck_s;
			tick  <= 1'b0;
			if (state == ST_IDLE || waiting)
				div_cnt <= 8'h00;
			else if (div_cnt == HALF_LAST)
			begin
				div_cnt <= 8'h00;
				tick    <= 1'b1;
			end
			else
				div_cnt <= div_cnt + 8'h01;
		end
	end

	// Register bus slave
	always @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= `SSR_RESP_OKAY;
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rresp_o   <= `SSR_RESP_OKAY;
			s_axi_rdata_o   <= 32'h0000_0000;
			aw_addr         <= 8'h00;
			w_data          <= 32'h0000_0000;
			w_lane0         <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_addr         <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_data         <= s_axi_wdata_i;
				w_lane0        <= s_axi_wstrb_i[0];
				s_axi_wready_o <= 1'b0;
			end
			if (wr_fire)
			begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= addr_ok(aw_addr) ? `SSR_RESP_OKAY : `SSR_RESP_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i)
			begin
				s_axi_bvalid_o  <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
			if (rd_fire)
			begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o  <= 1'b1;
				s_axi_rdata_o   <= rd_val;
				s_axi_rresp_o   <= addr_ok(s_axi_araddr_i) ? `SSR_RESP_OKAY : `SSR_RESP_SLVERR;
			end
			if (s_axi_rvalid_o && s_axi_rready_i)
			begin
				s_axi_rvalid_o  <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end

	// Control registers, buffer and shift sequencer
	always @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			state                <= ST_IDLE;
			shreg                <= 8'h00;
			bit_cnt              <= 3'h0;
			word_idx             <= 3'h0;
			word_count           <= `SSR_COUNT_RST;
			transfer_mode_field  <= `SSR_MODE_RST;
			transfer_start_bit   <= 1'b0;
			ext_clk              <= 1'b0;
			transfer_active_flag <= 1'b0;
			unread               <= 1'b0;
			sck_o                <= 1'b1;
			sck_oe_n_o           <= 1'b1;
			so_o                 <= 1'b1;
			serial_done_irq_o    <= 1'b0;
			for (i = 0; i < 8; i = i + 1)
				data_buffer_entries[i] <= `SSR_BUF_RST;
		end
		else
		begin
			serial_done_irq_o <= 1'b0;
			sck_oe_n_o        <= ext_clk;
			if (wr_ctl1)
			begin
				transfer_start_bit  <= w_data[`SSR_START_POS];
				ext_clk             <= w_data[`SSR_EXT_POS];
				transfer_mode_field <= w_data[`SSR_MODE_HI:`SSR_MODE_LO];
				if (abort_wr)
				begin
					transfer_start_bit   <= 1'b0;
					transfer_active_flag <= 1'b0;
					state                <= ST_IDLE;
					sck_o                <= 1'b1;
				end
				else if (w_data[`SSR_START_POS] && !transfer_active_flag)
				begin
					transfer_active_flag <= 1'b1;
					word_idx             <= 3'h0;
					unread               <= 1'b0;
					state                <= ST_READY;
				end
				if (w_data[`SSR_MODE_HI:`SSR_MODE_LO] != transfer_mode_field)
				begin
					word_idx <= 3'h0;
					for (i = 0; i < 8; i = i + 1)
						data_buffer_entries[i] <= `SSR_BUF_RST;
				end
			end
			if (wr_fire && w_lane0 && (aw_addr == `SSR_OFF_CTRL_TWO))
				word_count <= w_data[2:0];
			if (wr_fire && w_lane0 && is_buf(aw_addr))
			begin
				data_buffer_entries[aw_addr[4:2]] <= w_data[7:0];
				if (txrx)
					unread <= 1'b0;
			end
			// Outside combined mode any buffer read releases a receive wait, even outside the count
			if (rd_fire && is_buf(s_axi_araddr_i) && !txrx)
				unread <= 1'b0;
			if (!abort_wr)
			begin
				case (state)
					ST_IDLE:
					begin
						sck_o <= 1'b1;
					end
					ST_READY:
					begin
						if (!transfer_start_bit)
						begin
							transfer_active_flag <= 1'b0;
							state                <= ST_IDLE;
						end
						else if (!ext_clk && unread)
							sck_o <= 1'b1;
						else if (fall_ev)
						begin
							shreg   <= data_buffer_entries[word_idx];
							so_o    <= data_buffer_entries[word_idx][0];
							sck_o   <= 1'b0;
							bit_cnt <= 3'h0;
							state   <= ST_LOW;
						end
					end
					ST_LOW:
					begin
						if (rise_ev)
						begin
							sck_o <= 1'b1;
							shreg <= next_sh;
							if (bit_cnt != last_bit)
							begin
								bit_cnt <= bit_cnt + 3'h1;
								state   <= ST_HIGH;
							end
							else if (ext_clk && !txrx && unread)
							begin
								transfer_start_bit   <= 1'b0;
								transfer_active_flag <= 1'b0;
								state                <= ST_IDLE;
							end
							else
							begin
								data_buffer_entries[word_idx] <= rx_word;
								if (word_idx == word_count)
								begin
									serial_done_irq_o <= 1'b1;
									unread            <= 1'b1;
									word_idx          <= 3'h0;
								end
								else
									word_idx <= word_idx + 3'h1;
								if (!transfer_start_bit)
								begin
									transfer_active_flag <= 1'b0;
									state                <= ST_IDLE;
								end
								else
									state <= ST_READY;
							end
						end
					end
					ST_HIGH:
					begin
						if (fall_ev)
						begin
							so_o  <= shreg[0];
							sck_o <= 1'b0;
							state <= ST_LOW;
						end
					end
					default:
					begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

endmodule

// [verif/ssr_chk.sv]
module ssr_chk (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        nrst_i,
	// Register bus
	input wire logic [7:0]  s_axi_awaddr_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0]  s_axi_wstrb_i,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	// Serial pins and event
	input wire logic        sck_o,
	input wire logic        sck_oe_n_o,
	input wire logic        so_o,
	input wire logic        serial_done_irq_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic ext_q;
	wire  wr0 = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
		&& s_axi_awaddr_i == 8'h00 && s_axi_wstrb_i[0];
	always @(posedge clk_i)
	begin
		if (wr0) ext_q <= s_axi_wdata_i[4];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	property p_irq;
		serial_done_irq_o |=> !serial_done_irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("done pulse too long");
	property p_rst;
		$rose(nrst_i) |-> sck_o && so_o && sck_oe_n_o && !serial_done_irq_o;
	endproperty
	a_rst: assert property (p_rst) else $error("bad idle levels");
	property p_so;
		!sck_oe_n_o && sck_o && $past(sck_o) |-> $stable(so_o);
	endproperty
	a_so: assert property (p_so) else $error("data moved on trailing edge");
	property p_fall;
		!sck_oe_n_o && $fell(sck_o) |-> $past(sck_o, 8);
	endproperty
	a_fall: assert property (p_fall) else $error("clock high too short");
	property p_abort;
		wr0 && s_axi_wdata_i[1] |-> ##[1:3] (sck_o && !serial_done_irq_o) [*8];
	endproperty
	a_abort: assert property (p_abort) else $error("abort did not stop");
	property p_oe;
		wr0 |-> ##[2:4] sck_oe_n_o == ext_q;
	endproperty
	a_oe: assert property (p_oe) else $error("clock drive wrong");
	property p_bhold;
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_refuse;
		s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
	endproperty
	a_refuse: assert property (p_refuse) else $error("write taken early");
endmodule

bind ssr_core ssr_chk u_chk (
	.clk_i, .nrst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
	.s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
	.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
	.sck_o, .sck_oe_n_o, .so_o, .serial_done_irq_o
);

// [verif/ssr_peer.sv]
module ssr_peer (
	// Serial wires
	input  wire logic  sck_w,
	input  wire logic  so_w,
	output logic       si_o = 1'h1,
	output logic       sck_ext_o = 1'h1,
	output logic [7:0] rx_o = 8'h00
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] tx_q = 8'h00;
	int         idx = 0;
	int         width = 8;
	// Byte sent again for every word of the given width
	task load(input logic [7:0] v, input int w);
		tx_q = v;
		width = w;
		idx = 0;
	endtask
	// Clock stands high outside a frame
	task frame(input int n);
		#7;
		repeat (n)
		begin
			#100 sck_ext_o = 1'h0;
			#100 sck_ext_o = 1'h1;
		end
	endtask
	always @(negedge sck_w)
	begin
		si_o = tx_q[idx];
		idx = (idx + 1) % width;
	end
	always @(posedge sck_w)
	begin
		rx_o = {so_w, rx_o[7:1]};
	end
endmodule

// [verif/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_i = 1'h0;
	logic        nrst_i = 1'h0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'h0;
	logic        wvalid = 1'h0;
	logic        bready = 1'h0;
	logic        arvalid = 1'h0;
	logic        rready = 1'h0;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire         sck_o, sck_oe_n, so, si, sck_ext, irq;
	wire  [7:0]  peer_rx;
	wire         sck_w = sck_oe_n ? sck_ext : sck_o;
	logic [1:0]  resp;
	logic [31:0] d;
	logic [7:0]  b, t;
	int          n_mismatch = 0;
	int          checked = 0;
	int          m, k, c;
	always #12.5 clk_i = ~clk_i;
	ssr_core dut (
		.clk_i(clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n),
		.si_i(si), .so_o(so), .serial_done_irq_o(irq)
	);
	ssr_peer peer (.sck_w(sck_w), .so_w(so), .si_o(si), .sck_ext_o(sck_ext), .rx_o(peer_rx));
	function automatic logic [31:0] exp_rx(input int md, input logic [7:0] v);
		return (md == 1) ? {28'h0, v[3:0]} : {24'h0, v};
	endfunction
	task finish_test;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tmo(input int n, input int lim);
		if (n >= lim)
		begin
			chk(n, 0);
			finish_test;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
			if (awready === 1'h1) awvalid <= 1'h0;
			if (wready === 1'h1) wvalid <= 1'h0;
		end
		while (bvalid !== 1'h1 && n < 100);
		bready <= 1'h0;
		resp = bresp;
		tmo(n, 100);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v);
		int n;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
			if (arready === 1'h1) arvalid <= 1'h0;
		end
		while (rvalid !== 1'h1 && n < 100);
		rready <= 1'h0;
		v = rdata;
		resp = rresp;
		tmo(n, 100);
	endtask
	task wait_irq;
		int n;
		n = 0;
		do
			@(posedge clk_i);
		while (irq !== 1'h1 && ++n < 5000);
		tmo(n, 5000);
	endtask
	initial
	begin
		void'($urandom(2274));
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'h1;
		rd(8'h08, d);
		chk(d, 32'h0);
		rd(8'h10, d);
		chk(resp, 2'h2);
		wr(8'h10, 32'h0);
		chk(resp, 2'h2);
		for (m = 0; m < 3; m++)
		begin
			b = 8'($urandom);
			t = 8'($urandom);
			c = (m == 0) ? 7 : $urandom % 7;
			peer.load(b, (m == 1) ? 4 : 8);
			wr(8'h00, m << 2);
			rd(8'h3C, d);
			if (m == 1) chk(d, 32'h0);
			for (k = 0; k <= c; k++) wr(8'h20 + 8'(4 * k), {24'h0, 8'(t + k)});
			wr(8'h04, c);
			wr(8'h00, (m << 2) | 1);
			wait_irq;
			rd(8'h08, d);
			chk({d[2], d[0]}, 2'h3);
			wr(8'h04, c);
			if (m == 2) chk(peer_rx, 8'(t + c));
			if (m == 2)
			begin
				for (k = 0; k <= c; k++)
				begin
					rd(8'h20 + 8'(4 * k), d);
					chk(d, exp_rx(m, b));
				end
				rd(8'h08, d);
				chk(d[2], 1'h1);
				wr(8'h20, {24'h0, t});
			end
			else rd(8'h3C, d);
			rd(8'h08, d);
			chk(d[2], 1'h0);
			// Clear start only once the next word is on the wire
			k = 0;
			do
				rd(8'h08, d);
			while (d[1] !== 1'h1 && ++k < 300);
			tmo(k, 300);
			wr(8'h00, m << 2);
			k = 0;
			do
				rd(8'h08, d);
			while (d[0] !== 1'h0 && ++k < 300);
			tmo(k, 300);
			chk(k > 2, 1'h1);
			for (k = 0; k <= c; k++)
			begin
				rd(8'h20 + 8'(4 * k), d);
				chk(d, exp_rx(m, b));
			end
		end
		wr(8'h00, 32'h1);
		repeat (100) @(posedge clk_i);
		wr(8'h00, 32'h2);
		rd(8'h08, d);
		chk(d[0], 1'h0);
		rd(8'h20, d);
		chk(d, 32'h0);
		b = 8'($urandom);
		peer.load(b, 8);
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h11);
		peer.frame(8);
		repeat (8) @(posedge clk_i);
		rd(8'h08, d);
		chk(d[0], 1'h1);
		peer.load(~b, 8);
		peer.frame(8);
		repeat (8) @(posedge clk_i);
		rd(8'h08, d);
		chk(d[0], 1'h0);
		rd(8'h20, d);
		chk(d, exp_rx(0, b));
		// Combined mode on the external clock keeps running between words
		wr(8'h00, 32'h18);
		wr(8'h20, {24'h0, t});
		peer.load(b, 8);
		wr(8'h00, 32'h19);
		peer.frame(8);
		repeat (8) @(posedge clk_i);
		chk(peer_rx, t);
		rd(8'h20, d);
		chk(d, exp_rx(2, b));
		wr(8'h20, {24'h0, ~t});
		peer.frame(8);
		repeat (8) @(posedge clk_i);
		chk(peer_rx, 8'(~t));
		wr(8'h00, 32'h18);
		rd(8'h08, d);
		chk(d[0], 1'h0);
		finish_test;
	end
endmodule
